// [rtl/ras_state_top.sv]
// Operation
// - Bit k of request bytes two to six is socket k+1 of the chosen board.
// - Byte two set bit means socket exists, clear means it does not.
// - Byte three set bit marks the module failed, clear means good.
// - Byte four set bit marks the module disabled, clear means good.
// - Byte five set bit marks the module spare, clear means primary.
// - Byte six set bit means module installed, clear means empty socket.
// - One byte suffices when board is absent, otherwise six bytes needed.
// - Redundancy byte one bits 7:4 give domain type, sparing or mirroring.
// - Redundancy byte one bits 3:0 give domain instance, counted from one.
// - Redundancy byte two bits 1:0 give state, code three reserved.
// - Sparing instances name branches zero and one, mirroring only one instance.
// - Sufficient means degraded but working, insufficient means domain stopped.
// - Config byte one set bits enable matching sparing domains.
// - Config byte two set bits enable matching mirroring domains.
// - One presence sensor per domain follows that domain's mask bit.
// - Sparing mask bits are branches zero and one, mirror bit zero both.
// - Every set request is answered by one completion code byte.
// - Socket byte one bits 7:1 pick board one to four, bit 0 presence.
//
// Register access over Avalon-MM and the placing of the registers were left to the implementer.
module ras_state_top (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [7:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  output logic [7:0] o_spare_present,
  output logic [7:0] o_mirror_present
);
  typedef enum logic [0:0] {PH_IDLE, PH_EXEC} phase_t;

  // Maps a byte address onto a request byte slot
  function automatic logic [2:0] req_slot(input logic [7:0] addr);
    logic [7:0] rel;
    rel = addr - ras_pkg::REQ_OFF;
    if (addr >= ras_pkg::REQ_OFF && rel[1:0] == 2'h0
        && rel[7:2] < 6'(ras_pkg::REQ_BYTES))
      req_slot = rel[4:2];
    else
      req_slot = ras_pkg::NO_SLOT;
  endfunction : req_slot

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic wait_r;
  logic [31:0] rdata_r;
  phase_t phase_r;
  phase_t phase_nxt;
  logic [7:0] ctrl_r;
  logic [5:0][7:0] req_r;
  logic [7:0] cc_r;
  logic valid_r;
  logic valid_nxt;
  logic [1:0] sel_r;
  logic [1:0][1:0] spare_st_r;
  logic [1:0] mirror_st_r;
  logic [7:0] spare_mask_r;
  logic [7:0] mirror_mask_r;
  logic [31:0] maps;
  logic [8:0] inst;

  req_if rq ();

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire logic exec = (phase_r == PH_EXEC);
  // Hold off any access while a request is being executed
  wire logic first = (i_read | i_write) & wait_r & ~exec;
  wire logic wr_take = i_write & ~wait_r;
  wire logic rd_take = i_read & ~wait_r;
  wire logic lane0 = i_byteenable[0];
  wire logic [2:0] slot = req_slot(i_address);
  wire logic slot_hit = (slot != ras_pkg::NO_SLOT);
  wire logic ctrl_wr = wr_take & lane0 & (i_address == ras_pkg::CTRL_OFF);
  wire logic byte_wr = wr_take & lane0 & slot_hit;
  wire logic sel_wr = wr_take & lane0 & (i_address == ras_pkg::SEL_OFF);
  wire logic resp_rd = rd_take & (i_address == ras_pkg::RESP_OFF);

  wire logic [31:0] rd_mux =
      (i_address == ras_pkg::CTRL_OFF) ? {24'h0, ctrl_r}
    : slot_hit ? {24'h0, req_r[slot]}
    : (i_address == ras_pkg::RESP_OFF) ? {23'h0, valid_r, cc_r}
    : (i_address == ras_pkg::SEL_OFF) ? {30'h0, sel_r}
    : (i_address == ras_pkg::MAPS_OFF) ? maps
    : (i_address == ras_pkg::INST_OFF) ? {23'h0, inst}
    : (i_address == ras_pkg::REDUN_OFF) ? {26'h0, mirror_st_r, spare_st_r}
    : (i_address == ras_pkg::MASK_OFF) ? {16'h0, mirror_mask_r, spare_mask_r}
    : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode

  wire logic [1:0] op = ctrl_r[ras_pkg::CTRL_OP_LSB +: 2];
  wire logic [2:0] req_len = ctrl_r[ras_pkg::CTRL_LEN_LSB +: 3];
  wire logic ok = (rq.cc == ras_pkg::CC_OK);
  wire logic red_commit = exec & ok & (op == ras_pkg::OP_REDUN);
  wire logic cfg_commit = exec & ok & (op == ras_pkg::OP_CONFIG);
  wire logic [7:0] byte_one = req_r[0];
  wire logic [7:0] byte_two = req_r[1];
  wire logic [3:0] dom_type = byte_one[7:4];
  wire logic [3:0] dom_inst = byte_one[3:0];
  wire logic [3:0] branch_full = dom_inst - ras_pkg::INST_FIRST;
  wire logic branch = branch_full[0];
  // Redundant, degraded but working, or stopped
  wire logic [1:0] dom_state = byte_two[1:0];
  wire logic is_mirror = (dom_type == ras_pkg::DOM_MIRROR);
  wire logic [6:0] group_id = byte_one[7:1];

  assign rq.opcode = op;
  assign rq.len = req_len;
  assign rq.rb = req_r;
  // Stored state only moves on an accepted request
  assign rq.commit = exec & ok & (op == ras_pkg::OP_SOCKET);

  // Completion flag: a new answer beats a clearing read
  assign valid_nxt = exec ? 1'b1 : (resp_rd ? 1'b0 : valid_r);

  always_comb
  begin
    phase_nxt = PH_IDLE;
    case (phase_r)
      PH_IDLE: phase_nxt = ctrl_wr ? PH_EXEC : PH_IDLE;
      PH_EXEC: phase_nxt = PH_IDLE;
      default: phase_nxt = PH_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Submodules

  req_check u_check (
    .bus(rq.chk)
  );

  group_store #(
    .GROUPS(ras_pkg::GROUPS)
  ) u_store (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .bus(rq.store),
    .i_sel(sel_r),
    .o_maps(maps),
    .o_inst(inst)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave registers

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      wait_r <= 1'b1;
    else
      wait_r <= ~first;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      rdata_r <= 32'h0;
    else if (first)
      rdata_r <= i_read ? rd_mux : 32'h0;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      phase_r <= PH_IDLE;
    else
      phase_r <= phase_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      ctrl_r <= ras_pkg::BYTE_RESET;
    else if (ctrl_wr)
      ctrl_r <= i_writedata[7:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      req_r <= '0;
    else if (byte_wr)
      req_r[slot] <= i_writedata[7:0];
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      sel_r <= 2'h0;
    else if (sel_wr)
      sel_r <= i_writedata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Answer and domain state

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      cc_r <= ras_pkg::CC_OK;
    else if (exec)
      cc_r <= rq.cc;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
      valid_r <= 1'b0;
    else
      valid_r <= valid_nxt;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      spare_st_r <= {ras_pkg::STATE_RESET, ras_pkg::STATE_RESET};
      mirror_st_r <= ras_pkg::STATE_RESET;
    end
    else if (red_commit && is_mirror)
      mirror_st_r <= dom_state;
    else if (red_commit)
      spare_st_r[branch] <= dom_state;
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      spare_mask_r <= ras_pkg::MASK_RESET;
      mirror_mask_r <= ras_pkg::MASK_RESET;
    end
    else if (cfg_commit)
    begin
      spare_mask_r <= byte_one;
      mirror_mask_r <= byte_two;
    end
  end

  assign o_readdata = rdata_r;
  assign o_waitrequest = wait_r;
  // Each sensor tracks its domain's mask bit
  assign o_spare_present = spare_mask_r;
  assign o_mirror_present = mirror_mask_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence ack_seq;
    !wait_r ##1 wait_r;
  endsequence

  sequence exec_seq;
    exec ##1 (!exec && valid_r);
  endsequence

  bus_answer_a: assert property (first |=> ack_seq)
    else $error("waitrequest did not pulse low once");
  exec_answer_a: assert property (ctrl_wr |=> exec_seq)
    else $error("request not answered after control write");
  exec_hold_a: assert property (exec |-> wait_r)
    else $error("access answered during execution");
  resp_clear_a: assert property (resp_rd && !exec |=> !valid_r)
    else $error("completion flag not cleared by read");
  cc_capture_a: assert property (exec |=> cc_r == $past(rq.cc))
    else $error("completion code not captured");
  spare_sense_a: assert property (cfg_commit |=> o_spare_present == $past(byte_one))
    else $error("sparing sensors do not follow mask");
  mirror_sense_a: assert property (cfg_commit |=> o_mirror_present == $past(byte_two))
    else $error("mirroring sensors do not follow mask");
  reject_hold_a: assert property (exec && !ok |=> $stable(spare_mask_r)
      && $stable(mirror_mask_r) && $stable(spare_st_r) && $stable(mirror_st_r))
    else $error("rejected request changed state");
  spare_state_a: assert property (red_commit && !is_mirror
      |=> spare_st_r[$past(branch)] == $past(dom_state))
    else $error("sparing state not stored on its branch");
  mirror_state_a: assert property (red_commit && is_mirror
      |=> mirror_st_r == $past(dom_state) && $stable(spare_st_r))
    else $error("mirroring state misplaced");
  reserved_type_a: assert property (exec && op == ras_pkg::OP_REDUN
      && req_len == ras_pkg::LEN_RAS && dom_type > ras_pkg::DOM_MIRROR
      |-> rq.cc == ras_pkg::CC_BAD_FIELD)
    else $error("reserved domain type accepted");
  absent_short_a: assert property (exec && op == ras_pkg::OP_SOCKET
      && req_len == 3'h1 && !byte_one[0] && group_id >= ras_pkg::GROUP_ID_MIN
      && group_id <= ras_pkg::GROUP_ID_MAX |-> ok)
    else $error("one byte absent board request refused");
  present_short_a: assert property (exec && op == ras_pkg::OP_SOCKET && byte_one[0]
      && req_len < ras_pkg::LEN_SOCKET_FULL |-> !ok)
    else $error("short present board request accepted");

  // Bus slave guards
  bus_idle_a: assert property (!(i_read || i_write) |=> wait_r)
    else $error("waitrequest dropped with no access");
  lane_guard_a: assert property (wr_take && !lane0
      |=> $stable(ctrl_r) && $stable(req_r) && $stable(sel_r))
    else $error("write without lane zero changed a register");
  read_data_a: assert property (first && i_read |=> o_readdata == $past(rd_mux))
    else $error("read data not launched with the answer");
  write_silent_a: assert property (first && i_write |=> o_readdata == 32'h0)
    else $error("write answer carries read data");
  byte_store_a: assert property (byte_wr
      |=> req_r[$past(slot)] == $past(i_writedata[7:0]))
    else $error("request byte not stored");
  sel_store_a: assert property (sel_wr |=> sel_r == $past(i_writedata[1:0]))
    else $error("board select not stored");

  // Request guards
  exec_once_a: assert property (exec |=> !exec)
    else $error("request executed twice");
  flag_set_a: assert property (exec |=> valid_r)
    else $error("completion flag not raised");
  cfg_length_a: assert property (exec && op == ras_pkg::OP_CONFIG
      && req_len != ras_pkg::LEN_RAS |-> !ok)
    else $error("configuration request of wrong length accepted");
  bad_opcode_a: assert property (exec && op == 2'h0
      |-> rq.cc == ras_pkg::CC_BAD_CMD)
    else $error("unknown request accepted");
  reserved_state_a: assert property (exec && op == ras_pkg::OP_REDUN
      && dom_state == ras_pkg::ST_RESERVED |-> !ok)
    else $error("reserved domain state accepted");
  mirror_inst_a: assert property (red_commit && is_mirror
      |-> dom_inst == ras_pkg::MIRROR_INST_MAX)
    else $error("mirroring stored with a bad instance");
  spare_inst_a: assert property (red_commit && !is_mirror
      |-> dom_inst >= ras_pkg::INST_FIRST && dom_inst <= ras_pkg::SPARE_INST_MAX)
    else $error("sparing stored with a bad instance");
  bad_group_a: assert property (exec && op == ras_pkg::OP_SOCKET
      && (group_id < ras_pkg::GROUP_ID_MIN || group_id > ras_pkg::GROUP_ID_MAX) |-> !ok)
    else $error("socket request for a missing board accepted");
  sensor_hold_a: assert property (!cfg_commit |=> $stable(o_spare_present)
      && $stable(o_mirror_present))
    else $error("presence sensors moved without configuration");
endmodule : ras_state_top

// [include/ras_pkg.sv]
package ras_pkg;
  // Byte addresses of the register window, then the request byte and board counts
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] REQ_OFF = 8'h04;
  localparam logic [7:0] RESP_OFF = 8'h1c;
  localparam logic [7:0] SEL_OFF = 8'h20;
  localparam logic [7:0] MAPS_OFF = 8'h24;
  localparam logic [7:0] INST_OFF = 8'h28;
  localparam logic [7:0] REDUN_OFF = 8'h2c;
  localparam logic [7:0] MASK_OFF = 8'h30;
  localparam int REQ_BYTES = 6;
  localparam int GROUPS = 4;
  // Control register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_LEN_LSB = 4;
  localparam logic [1:0] OP_SOCKET = 2'h1;
  localparam logic [1:0] OP_REDUN = 2'h2;
  localparam logic [1:0] OP_CONFIG = 2'h3;
  // Completion codes
  localparam logic [7:0] CC_OK = 8'h00;
  localparam logic [7:0] CC_BAD_CMD = 8'hc1;
  localparam logic [7:0] CC_SHORT = 8'hc7;
  localparam logic [7:0] CC_LONG = 8'hc8;
  localparam logic [7:0] CC_BAD_FIELD = 8'hcc;
  // Request field values
  localparam logic [2:0] LEN_SOCKET_FULL = 3'h6;
  localparam logic [2:0] LEN_RAS = 3'h2;
  localparam logic [6:0] GROUP_ID_MIN = 7'h01;
  localparam logic [6:0] GROUP_ID_MAX = 7'h04;
  localparam logic [3:0] DOM_SPARING = 4'h0;
  localparam logic [3:0] DOM_MIRROR = 4'h1;
  localparam logic [3:0] SPARE_INST_MAX = 4'h2;
  localparam logic [3:0] MIRROR_INST_MAX = 4'h1;
  localparam logic [3:0] INST_FIRST = 4'h1;
  localparam logic [1:0] ST_RESERVED = 2'h3;
  // Values after reset, and the no-slot code
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] STATE_RESET = 2'h0;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [2:0] NO_SLOT = 3'h7;
endpackage : ras_pkg

// [include/req_if.sv]
interface req_if;
  logic [1:0] opcode;
  logic [2:0] len;
  logic [5:0][7:0] rb;
  logic commit;
  logic [7:0] cc;
  logic [1:0] grp;
  modport src (output opcode, output len, output rb, output commit, input cc, input grp);
  modport chk (input opcode, input len, input rb, output cc, output grp);
  modport store (input rb, input commit, input grp);
endinterface : req_if

// [rtl/req_check.sv]
module req_check (
  req_if.chk bus
);
  function automatic logic [7:0] socket_cc(input logic [2:0] len, input logic [7:0] b0);
    logic [6:0] id;
    id = b0[7:1];
    if (len == 3'h0)
      socket_cc = ras_pkg::CC_SHORT;
    else if (len > ras_pkg::LEN_SOCKET_FULL)
      socket_cc = ras_pkg::CC_LONG;
    else if (id < ras_pkg::GROUP_ID_MIN || id > ras_pkg::GROUP_ID_MAX)
      socket_cc = ras_pkg::CC_BAD_FIELD;
    else if (!b0[0])
      socket_cc = ras_pkg::CC_OK;
    else if (len < ras_pkg::LEN_SOCKET_FULL)
      socket_cc = ras_pkg::CC_SHORT;
    else
      socket_cc = ras_pkg::CC_OK;
  endfunction : socket_cc

  function automatic logic [7:0] ras_cc(input logic [2:0] len, input logic [7:0] b0,
                                        input logic [7:0] b1);
    logic [3:0] kind;
    logic [3:0] inst;
    kind = b0[7:4];
    inst = b0[3:0];
    if (len < ras_pkg::LEN_RAS)
      ras_cc = ras_pkg::CC_SHORT;
    else if (len > ras_pkg::LEN_RAS)
      ras_cc = ras_pkg::CC_LONG;
    else if (kind == ras_pkg::DOM_SPARING)
      ras_cc = (inst < ras_pkg::INST_FIRST || inst > ras_pkg::SPARE_INST_MAX)
             ? ras_pkg::CC_BAD_FIELD : ras_pkg::CC_OK;
    else if (kind == ras_pkg::DOM_MIRROR)
      ras_cc = (inst != ras_pkg::MIRROR_INST_MAX)
             ? ras_pkg::CC_BAD_FIELD : ras_pkg::CC_OK;
    else
      ras_cc = ras_pkg::CC_BAD_FIELD;
    if (ras_cc == ras_pkg::CC_OK && b1[1:0] == ras_pkg::ST_RESERVED)
      ras_cc = ras_pkg::CC_BAD_FIELD;
  endfunction : ras_cc

  wire logic [6:0] grp_full = bus.rb[0][7:1] - ras_pkg::GROUP_ID_MIN;
  wire logic [7:0] cfg_cc = (bus.len < ras_pkg::LEN_RAS) ? ras_pkg::CC_SHORT
                          : (bus.len > ras_pkg::LEN_RAS) ? ras_pkg::CC_LONG : ras_pkg::CC_OK;

  // Group id 1..4 selects riser board slot 0..3
  assign bus.grp = grp_full[1:0];
  assign bus.cc = (bus.opcode == ras_pkg::OP_SOCKET) ? socket_cc(bus.len, bus.rb[0])
                : (bus.opcode == ras_pkg::OP_REDUN) ? ras_cc(bus.len, bus.rb[0], bus.rb[1])
                : (bus.opcode == ras_pkg::OP_CONFIG) ? cfg_cc
                : ras_pkg::CC_BAD_CMD;
endmodule : req_check

// [rtl/group_store.sv]
module group_store #(
  parameter int GROUPS = ras_pkg::GROUPS
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  req_if.store bus,
  input wire logic [1:0] i_sel,
  output logic [31:0] o_maps,
  output logic [8:0] o_inst
);
  logic [7:0] exist_r [GROUPS];
  logic [7:0] fail_r [GROUPS];
  logic [7:0] dis_r [GROUPS];
  logic [7:0] spare_r [GROUPS];
  logic [7:0] inst_r [GROUPS];
  logic [GROUPS-1:0] board_r;

  wire logic present = bus.rb[0][0];

  // Absent board keeps no module state
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      for (int g = 0; g < GROUPS; g++)
      begin
        exist_r[g] <= ras_pkg::BYTE_RESET;
        fail_r[g] <= ras_pkg::BYTE_RESET;
        dis_r[g] <= ras_pkg::BYTE_RESET;
        spare_r[g] <= ras_pkg::BYTE_RESET;
        inst_r[g] <= ras_pkg::BYTE_RESET;
      end
      board_r <= '0;
    end
    else if (bus.commit)
    begin
      board_r[bus.grp] <= present;
      exist_r[bus.grp] <= present ? bus.rb[1] : ras_pkg::BYTE_RESET;
      fail_r[bus.grp] <= present ? bus.rb[2] : ras_pkg::BYTE_RESET;
      dis_r[bus.grp] <= present ? bus.rb[3] : ras_pkg::BYTE_RESET;
      spare_r[bus.grp] <= present ? bus.rb[4] : ras_pkg::BYTE_RESET;
      inst_r[bus.grp] <= present ? bus.rb[5] : ras_pkg::BYTE_RESET;
    end
  end

  // Bit k of each map is socket k+1 of the selected board
  assign o_maps = {spare_r[i_sel], dis_r[i_sel], fail_r[i_sel], exist_r[i_sel]};
  assign o_inst = {board_r[i_sel], inst_r[i_sel]};

  store_maps_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    bus.commit && present |=> fail_r[$past(bus.grp)] == $past(bus.rb[2])
      && inst_r[$past(bus.grp)] == $past(bus.rb[5]))
    else $error("socket maps not stored");
  store_absent_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    bus.commit && !present |=> !board_r[$past(bus.grp)]
      && exist_r[$past(bus.grp)] == ras_pkg::BYTE_RESET)
    else $error("absent board not cleared");
endmodule : group_store

// [sim/host_fw.sv]
////////////////////////////////////////////////////////////////////////
// Boot firmware side: Avalon master issuing management requests
module host_fw (
  input wire logic i_mclk,
  input wire logic i_waitrequest,
  output logic [7:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_address = 8'h00;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h0;
    o_byteenable = 4'h0;
  end
  // One access, held until waitrequest is seen low
  task automatic xfer(input logic [7:0] a, input logic rd, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge i_mclk);
    o_address <= a;
    o_read <= rd;
    o_write <= !rd;
    o_writedata <= d;
    o_byteenable <= be;
    @(posedge i_mclk);
    while (i_waitrequest !== 1'b0)
      @(posedge i_mclk);
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released lines show no stale value
    o_address <= ~a;
    o_writedata <= ~d;
  endtask : xfer
endmodule : host_fw

// [sim/testbench.sv]
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h want %h", $time, g, e); end end
////////////////////////////////////////////////////////////////////////
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk;
  logic i_rst;
  logic [7:0] addr;
  logic rd_w;
  logic wr_w;
  logic [31:0] wd;
  logic [31:0] rdata;
  logic [3:0] be;
  logic wait_w;
  logic [7:0] sp;
  logic [7:0] mp;
  logic [31:0] exp_q[$];
  logic [31:0] e_m;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  ras_state_top ras_state_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(addr),
    .i_read(rd_w), .i_write(wr_w), .i_writedata(wd), .i_byteenable(be),
    .o_readdata(rdata), .o_waitrequest(wait_w), .o_spare_present(sp),
    .o_mirror_present(mp));
  host_fw host_fw_inst (.i_mclk(i_mclk), .i_waitrequest(wait_w), .o_address(addr),
    .o_read(rd_w), .o_write(wr_w), .o_writedata(wd), .o_byteenable(be));
  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Oldest noted read result against the answer on the bus
  always @(posedge i_mclk)
  begin
    cyc++;
    if (rd_w === 1'b1 && wait_w === 1'b0)
    begin
      e_m = exp_q.pop_front();
      `CHK(rdata, e_m)
    end
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    host_fw_inst.xfer(a, 1'b1, 32'h0, 4'hf);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_fw_inst.xfer(a, 1'b0, d, 4'h1);
  endtask : wr
  // Request bytes, then the start word, then the completion word
  task automatic cmd(input logic [1:0] op, input logic [2:0] n, input logic [47:0] b,
                     input logic [7:0] cc);
    for (int i = 0; i < 6; i++)
      wr(ras_pkg::REQ_OFF + 8'(4 * i), {24'h0, b[8 * i +: 8]});
    wr(ras_pkg::CTRL_OFF, {25'h0, n, 2'h0, op});
    rd(ras_pkg::RESP_OFF, {23'h0, 1'b1, cc});
  endtask : cmd
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] rng;
    logic [31:0] st [1:4];
    logic [23:0] rt [9];
    logic [5:0] rs;
    int f;
    rng = 32'h256e;
    rs = 6'h0;
    rt = '{24'h010200, 24'h02fd00, 24'h110100, 24'h2100cc, 24'h0103cc, 24'h0300cc,
           24'h0000cc, 24'h1200cc, 24'h110000};
    i_rst = 1'b1;
    repeat (10) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(ras_pkg::MASK_OFF, 32'h0);
    `CHK({sp, mp}, 16'h0)
    $display("test reset done");
    for (int g = 1; g <= 4; g++)
    begin
      rng = xs(rng);
      st[g] = rng;
      // All eight sockets exist on every board
      cmd(ras_pkg::OP_SOCKET, 3'h6, {rng, 8'hff, 7'(g), 1'b1}, 8'h00);
    end
    for (int g = 1; g <= 4; g++)
    begin
      wr(ras_pkg::SEL_OFF, 32'(g - 1));
      rd(ras_pkg::MAPS_OFF, {st[g][23:0], 8'hff});
      rd(ras_pkg::INST_OFF, {23'h0, 1'b1, st[g][31:24]});
    end
    $display("test socket done");
    cmd(ras_pkg::OP_SOCKET, 3'h5, 48'h09, 8'hc7);
    cmd(ras_pkg::OP_SOCKET, 3'h0, 48'h09, 8'hc7);
    cmd(ras_pkg::OP_SOCKET, 3'h7, 48'h09, 8'hc8);
    cmd(ras_pkg::OP_SOCKET, 3'h6, 48'h0b, 8'hcc);
    rd(ras_pkg::MAPS_OFF, {st[4][23:0], 8'hff});
    cmd(ras_pkg::OP_SOCKET, 3'h1, 48'h04, 8'h00);
    wr(ras_pkg::SEL_OFF, 32'h1);
    rd(ras_pkg::MAPS_OFF, 32'h0);
    rd(ras_pkg::INST_OFF, 32'h0);
    host_fw_inst.xfer(ras_pkg::SEL_OFF, 1'b0, 32'h3, 4'he);
    rd(ras_pkg::SEL_OFF, 32'h1);
    $display("test socket errors done");
    for (int i = 0; i < 9; i++)
    begin
      cmd(ras_pkg::OP_REDUN, 3'h2, {32'h0, rt[i][15:8], rt[i][23:16]}, rt[i][7:0]);
      if (rt[i][7:0] == 8'h00)
      begin
        f = rt[i][20] ? 2 : int'(rt[i][17:16]) - 1;
        rs[2 * f +: 2] = rt[i][9:8];
      end
      rd(ras_pkg::REDUN_OFF, {26'h0, rs});
    end
    $display("test redundancy done");
    repeat (2)
    begin
      rng = xs(rng);
      cmd(ras_pkg::OP_CONFIG, 3'h2, {32'h0, rng[15:0]}, 8'h00);
      rd(ras_pkg::MASK_OFF, {16'h0, rng[15:0]});
      `CHK({mp, sp}, rng[15:0])
    end
    cmd(ras_pkg::OP_CONFIG, 3'h3, 48'hffff, 8'hc8);
    `CHK({mp, sp}, rng[15:0])
    $display("test config done");
    cmd(2'h0, 3'h2, 48'h0, 8'hc1);
    rd(ras_pkg::RESP_OFF, 32'hc1);
    wr(8'h3c, 32'hff);
    rd(8'h3c, 32'h0);
    $display("test misc done");
    repeat (3) @(posedge i_mclk);
    give_verdict();
  end
endmodule : testbench
